// ### hdl/afc_pkg.sv
// Shared constants for the frequency offset control block and its host
package afc_pkg;
    // Clock and timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int MEAS_TIME_NS = 1600;
    localparam logic [7:0] MEAS_CYC =
        8'((MEAS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int SPI_HALF_NS = 200;
    localparam logic [3:0] SPI_HALF_CYC =
        4'((SPI_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [4:0] FRAME_BITS = 5'h10;
    // Serial command frame layout
    localparam int CMD_WR_BIT = 15;
    localparam logic [15:0] CMD_READ_STATUS = 16'h0000;
    // Offset control register fields
    localparam int CTL_MODE_HI = 7;
    localparam int CTL_MODE_LO = 6;
    localparam int CTL_STROBE_BIT = 3;
    localparam int CTL_APPLY_BIT = 0;
    localparam logic [7:0] CTL_RST = 8'h00;
    // Status word fields
    localparam int STS_DONE_BIT = 5;
    localparam int STS_OFS_LSB = 0;
    localparam logic [15:0] STS_RST = 16'h0000;
    // Offset modes
    typedef enum logic [1:0] {
        MODE_MANUAL = 2'b00,
        MODE_ONCE = 2'b01,
        MODE_DROP = 2'b10,
        MODE_KEEP = 2'b11
    } afc_mode_t;
    // Host register map (word index on the host register port)
    localparam logic [2:0] HR_CTRL = 3'h0;
    localparam logic [2:0] HR_STATUS = 3'h1;
    localparam logic [2:0] HR_CMD = 3'h2;
    localparam logic [2:0] HR_IRQ_STS = 3'h3;
    localparam logic [2:0] HR_IRQ_MASK = 3'h4;
    localparam int IRQ_FRAME_BIT = 0;
    localparam int IRQ_MDONE_BIT = 1;
    localparam logic [1:0] IRQ_RST = 2'h0;
endpackage

// ### hdl/afc_spi_if.sv
// Serial command link between host controller and offset control block
`timescale 1ns/1ps
interface afc_spi_if;
    logic sck;
    logic cs_n;
    logic mosi;
    logic miso;
    modport dev (input sck, input cs_n, input mosi, output miso);
    modport host (output sck, output cs_n, output mosi, input miso);
endinterface

// ### hdl/afc_meas.sv
// Measurement cycle timer and result sampler
`timescale 1ns/1ps
module afc_meas (
    input wire logic clk, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic ce, // Clock enable
    input wire logic restart, // Start a fresh cycle
    input wire logic dv, // Data valid indicator
    input wire logic [3:0] raw, // Raw offset from discriminator
    output logic cyc_end, // Pulse: cycle completed
    output logic dv_whole, // Valid held through whole cycle
    output logic [3:0] result // Offset sampled at cycle end
);
    typedef struct packed {
        logic [7:0] cnt;
        logic dv_all;
        logic cyc_end;
        logic dv_whole;
        logic [3:0] result;
    } afc_meas_st_t;

    afc_meas_st_t r;
    afc_meas_st_t n;

    // Last count of a measurement cycle
    localparam logic [7:0] MEAS_CYC_M1 = afc_pkg::MEAS_CYC - 8'h01;

    // Count one cycle, track valid and sample at its end
    always_comb begin
        n = r;
        n.cyc_end = 1'b0;
        if (restart) begin
            n.cnt = 8'h00;
            n.dv_all = 1'b1;
        end else if (r.cnt == MEAS_CYC_M1) begin
            n.cnt = 8'h00;
            n.dv_all = 1'b1;
            n.cyc_end = 1'b1;
            n.dv_whole = r.dv_all & dv;
            n.result = raw;
        end else begin
            n.cnt = r.cnt + 8'h01;
            n.dv_all = r.dv_all & dv;
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '{8'h00, 1'b1, 1'b0, 1'b0, 4'h0};
        end else if (ce) begin
            r <= n;
        end
    end

    assign cyc_end = r.cyc_end;
    assign dv_whole = r.dv_whole;
    assign result = r.result;
endmodule

// ### hdl/afc_dev.sv
// Frequency offset control block with its serial command port
`timescale 1ns/1ps
module afc_dev (
    input wire logic clk, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic ce, // Clock enable
    afc_spi_if.dev spi, // Serial command port
    input wire logic dv, // Data valid indicator
    input wire logic [3:0] raw_offset, // Raw measured offset
    input wire logic [11:0] base_word, // Synthesizer frequency word
    output logic [11:0] synth_word, // Corrected frequency word
    output logic [3:0] offset_value // Stored offset
);
    // Whole state of the block, registered in one place
    typedef struct packed {
        logic sck_q;
        logic cs_q;
        logic [4:0] bits;
        logic [15:0] rx;
        logic [15:0] tx;
        logic miso;
        logic [7:0] ctrl;
        logic [3:0] ofs;
        logic done;
        logic pend;
        logic once;
        logic prev_ok;
        logic [3:0] prev;
        logic [11:0] synth;
    } afc_dev_st_t;

    afc_dev_st_t r;
    afc_dev_st_t n;
    // Decoded link events and one-cycle strobes
    logic strobe;
    logic rd_clr;
    logic upd;
    logic match;
    logic rise;
    logic fall;
    logic cs_fall;
    logic cs_rise;
    logic m_end;
    logic m_dvw;
    logic [3:0] m_res;
    afc_pkg::afc_mode_t mode;

    // Status word from stored offset and done flag
    function automatic logic [15:0] sts_word(input logic [3:0] ofs,
                                             input logic done);
        logic [15:0] w;
        w = afc_pkg::STS_RST;
        w[afc_pkg::STS_OFS_LSB +: 4] = ofs;
        w[afc_pkg::STS_DONE_BIT] = done;
        return w;
    endfunction

    // Measurement cycle engine
    afc_meas u_meas (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .restart(strobe),
        .dv(dv),
        .raw(raw_offset),
        .cyc_end(m_end),
        .dv_whole(m_dvw),
        .result(m_res)
    );

    // Link edge detection
    // Edges show one clock late; each host phase lasts two clocks
    assign rise = spi.sck & ~r.sck_q;
    assign fall = ~spi.sck & r.sck_q;
    assign cs_fall = ~spi.cs_n & r.cs_q;
    assign cs_rise = spi.cs_n & ~r.cs_q;
    // Mode field decoded once for every user
    assign mode = afc_pkg::afc_mode_t'(
        r.ctrl[afc_pkg::CTL_MODE_HI:afc_pkg::CTL_MODE_LO]);
    // A cycle counts only if valid held all through it
    // two matching whole-valid cycles
    assign match = r.prev_ok & m_dvw & (m_res == r.prev);

    // Next-state logic
    always_comb begin
        n = r;
        strobe = 1'b0;
        rd_clr = 1'b0;
        upd = 1'b0;
        // Sample link pins for edge detection next cycle
        n.sck_q = spi.sck;
        n.cs_q = spi.cs_n;
        if (cs_fall) begin
            // Load the status word as the frame opens
            n.bits = 5'h00;
            n.tx = sts_word(r.ofs, r.done);
            n.miso = n.tx[15];
        end else if (!spi.cs_n) begin
            if (rise) begin
                n.rx = {r.rx[14:0], spi.mosi};
                // Saturate so an overlong frame never wraps to 16
                if (r.bits != 5'h1F) begin
                    n.bits = r.bits + 5'h01;
                end
            end
            if (fall) begin
                // Next status bit leaves after each falling edge
                n.tx = {r.tx[14:0], 1'b0};
                n.miso = r.tx[14];
            end
        end
        // Execute a complete frame when select rises
        // A frame with any other bit count is dropped whole
        if (cs_rise && r.bits == afc_pkg::FRAME_BITS) begin
            if (r.rx[afc_pkg::CMD_WR_BIT]) begin
                n.ctrl = r.rx[7:0];
                strobe = r.rx[afc_pkg::CTL_STROBE_BIT];
            end else begin
                rd_clr = 1'b1;
            end
        end
        // Measurement results by mode
        if (m_end) begin
            n.prev = m_res;
            n.prev_ok = m_dvw;
            // A strobe is spent by the cycle it started, in any mode
            n.pend = 1'b0;
            unique case (mode)
                afc_pkg::MODE_MANUAL: begin
                    upd = r.pend;
                end
                afc_pkg::MODE_ONCE: begin
                    if (!r.once && match) begin
                        upd = 1'b1;
                        n.once = 1'b1;
                    end
                end
                afc_pkg::MODE_DROP, afc_pkg::MODE_KEEP: begin
                    upd = match;
                end
            endcase
        end
        // A new strobe arms the update of the cycle it restarts
        if (strobe) begin
            n.pend = 1'b1;
        end
        if (upd) begin
            n.ofs = m_res;
        end
        // Valid low wins over an update in the same cycle
        // drop offset when valid falls
        if (mode == afc_pkg::MODE_DROP && !dv) begin
            n.ofs = 4'h0;
        end
        if (upd) begin
            n.done = 1'b1;
        end else if (rd_clr) begin
            n.done = 1'b0;
        end
        // Sign extension lets a negative offset lower the word
        // apply offset to frequency word
        if (r.ctrl[afc_pkg::CTL_APPLY_BIT]) begin
            n.synth = base_word + {{8{r.ofs[3]}}, r.ofs};
        end else begin
            n.synth = base_word;
        end
    end

    // Clock enable low freezes every field, link edges too
    // reset clears offset and done
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '{1'b0, 1'b1, 5'h00, 16'h0000, 16'h0000, 1'b0,
                   afc_pkg::CTL_RST, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0,
                   4'h0, 12'h000};
        end else if (ce) begin
            r <= n;
        end
    end

    // Outputs come straight from the state register
    // done flag reaches host via status
    assign spi.miso = r.miso;
    assign synth_word = r.synth;
    assign offset_value = r.ofs;
endmodule

// ### hdl/afc_host.sv
// Host controller issuing serial command frames to the offset block
`timescale 1ns/1ps
module afc_host (
    input wire logic clk, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic ce, // Clock enable
    afc_spi_if.host spi, // Serial command port
    input wire logic [2:0] addr, // Register index
    input wire logic [15:0] wdata, // Write data
    input wire logic wr, // Write strobe
    input wire logic rd, // Read strobe
    output logic [15:0] rdata, // Read data, cycle after rd
    output logic irq // Interrupt, level
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DIS = 3'b001,
        ST_RD = 3'b010,
        ST_RES = 3'b011,
        ST_WR = 3'b100
    } afc_hst_state_t;

    typedef struct packed {
        afc_hst_state_t st;
        logic act;
        logic [3:0] cnt;
        logic [4:0] bitn;
        logic sck;
        logic cs_n;
        logic mosi;
        logic [15:0] sh;
        logic [15:0] rxs;
        logic [7:0] ctrl;
        logic [15:0] status;
        logic [1:0] irqs;
        logic [1:0] mask;
        logic pend_wr;
        logic pend_rd;
        logic [15:0] rdata;
        logic irq;
    } afc_hst_st_t;

    afc_hst_st_t r;
    afc_hst_st_t n;
    logic fdone;
    logic [15:0] word;
    logic [7:0] safe;

    localparam logic [3:0] HALF_M1 = afc_pkg::SPI_HALF_CYC - 4'h1;

    // Frame word for each sequencer state
    always_comb begin
        safe = r.ctrl;
        safe[afc_pkg::CTL_STROBE_BIT] = 1'b0;
        word = {8'h80, r.ctrl};
        unique case (r.st)
            ST_DIS: word = {8'h80, safe & 8'hFE};
            ST_RD: word = afc_pkg::CMD_READ_STATUS;
            ST_RES: word = {8'h80, safe};
            ST_IDLE, ST_WR: word = {8'h80, r.ctrl};
        endcase
    end

    // Sequencer, frame engine and registers
    always_comb begin
        n = r;
        fdone = 1'b0;
        if (r.st != ST_IDLE && !r.act) begin
            n.act = 1'b1;
            n.cs_n = 1'b0;
            n.sck = 1'b0;
            n.cnt = 4'h0;
            n.bitn = 5'h00;
            n.sh = word;
            n.mosi = word[15];
        end else if (r.act) begin
            if (r.cnt != HALF_M1) begin
                n.cnt = r.cnt + 4'h1;
            end else begin
                n.cnt = 4'h0;
                if (!r.sck) begin
                    n.sck = 1'b1;
                    n.rxs = {r.rxs[14:0], spi.miso};
                    n.bitn = r.bitn + 5'h01;
                end else if (r.bitn == afc_pkg::FRAME_BITS) begin
                    n.sck = 1'b0;
                    n.cs_n = 1'b1;
                    n.act = 1'b0;
                    fdone = 1'b1;
                end else begin
                    n.sck = 1'b0;
                    n.sh = {r.sh[14:0], 1'b0};
                    n.mosi = r.sh[14];
                end
            end
        end
        // Sequence steps after each frame
        if (fdone) begin
            unique case (r.st)
                ST_DIS: n.st = ST_RD;
                ST_RD: begin
                    n.status = r.rxs;
                    n.irqs[afc_pkg::IRQ_FRAME_BIT] = 1'b1;
                    if (r.rxs[afc_pkg::STS_DONE_BIT]) begin
                        n.irqs[afc_pkg::IRQ_MDONE_BIT] = 1'b1;
                    end
                    n.st = r.ctrl[afc_pkg::CTL_APPLY_BIT] ? ST_RES : ST_IDLE;
                end
                ST_IDLE, ST_RES, ST_WR: n.st = ST_IDLE;
            endcase
        end else if (r.st == ST_IDLE) begin
            if (r.pend_rd) begin
                n.pend_rd = 1'b0;
                n.st = r.ctrl[afc_pkg::CTL_APPLY_BIT] ? ST_DIS : ST_RD;
            end else if (r.pend_wr) begin
                n.pend_wr = 1'b0;
                n.st = ST_WR;
            end
        end
        // Register writes; event set wins over clear unless its bit was already set
        if (wr) begin
            unique case (addr)
                afc_pkg::HR_CTRL: begin
                    n.ctrl = wdata[7:0];
                    n.pend_wr = 1'b1;
                end
                afc_pkg::HR_CMD: n.pend_rd = n.pend_rd | wdata[0];
                afc_pkg::HR_IRQ_STS: n.irqs = n.irqs & ~(wdata[1:0] & ~(
                    n.irqs ^ r.irqs));
                afc_pkg::HR_IRQ_MASK: n.mask = wdata[1:0];
                default: n.mask = r.mask;
            endcase
        end
        // Register reads, data stands one cycle
        n.rdata = 16'h0000;
        if (rd) begin
            unique case (addr)
                afc_pkg::HR_CTRL: n.rdata = {8'h00, r.ctrl};
                afc_pkg::HR_STATUS: n.rdata = r.status;
                afc_pkg::HR_CMD: n.rdata = {15'h0000,
                    (r.st != ST_IDLE) | r.pend_rd | r.pend_wr};
                afc_pkg::HR_IRQ_STS: n.rdata = {14'h0000, r.irqs};
                afc_pkg::HR_IRQ_MASK: n.rdata = {14'h0000, r.mask};
                default: n.rdata = 16'h0000;
            endcase
        end
        n.irq = |(n.irqs & n.mask);
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '{ST_IDLE, 1'b0, 4'h0, 5'h00, 1'b0, 1'b1, 1'b0,
                   16'h0000, 16'h0000, afc_pkg::CTL_RST, afc_pkg::STS_RST,
                   afc_pkg::IRQ_RST, afc_pkg::IRQ_RST, 1'b0, 1'b0,
                   16'h0000, 1'b0};
        end else if (ce) begin
            r <= n;
        end
    end

    assign spi.sck = r.sck;
    assign spi.cs_n = r.cs_n;
    assign spi.mosi = r.mosi;
    assign rdata = r.rdata;
    assign irq = r.irq;
endmodule

// ### tb/afc_chk.sv
// Framing and status-shift checks on the serial command wire
`timescale 1ns/1ps
module afc_chk (
    input wire logic clk, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic sck, // Serial clock
    input wire logic cs_n, // Frame select, active low
    input wire logic mosi, // Host to device data
    input wire logic miso // Device to host data
);
    logic [4:0] cnt_r; // Serial clock rises in this frame
    logic sck_r; // Serial clock one cycle ago
    logic rd_r; // Current frame is a status read
    logic rise;
    assign rise = sck && !sck_r;
    // Count rises per frame and note the command kind
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 5'h00;
            sck_r <= 1'b0;
            rd_r <= 1'b0;
        end else begin
            sck_r <= sck;
            if (cs_n) begin
                cnt_r <= 5'h00;
            end else if (rise) begin
                cnt_r <= cnt_r + 5'h01;
                if (cnt_r == 5'h00) begin
                    rd_r <= !mosi;
                end
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_high2; sck ##1 !sck; endsequence
    sequence s_low2; !sck ##1 !sck ##1 sck; endsequence
    property p_idle; cs_n |-> !sck; endproperty
    property p_hi; $rose(sck) |-> ##1 s_high2; endproperty
    property p_lo; $fell(sck) && !cs_n |-> s_low2; endproperty
    property p_start; $fell(cs_n) |-> s_low2; endproperty
    property p_mosi; sck && $past(sck) |-> $stable(mosi); endproperty
    property p_bits; $rose(cs_n) |-> cnt_r == 5'h10; endproperty
    property p_max; !cs_n |-> cnt_r <= 5'h10; endproperty
    // Status word bits 15:6 and 4 always shift out as zero
    property p_zero;
        rise && (cnt_r == 5'h00 ? !mosi : rd_r)
            && (cnt_r < 5'h0A || cnt_r == 5'h0B) |-> !miso;
    endproperty
    a_idle: assert property (p_idle)
        else $error("serial clock runs outside a frame");
    a_hi: assert property (p_hi)
        else $error("serial clock high phase not two cycles");
    a_lo: assert property (p_lo)
        else $error("serial clock low phase not two cycles");
    a_start: assert property (p_start)
        else $error("first rise not two cycles after select");
    a_mosi: assert property (p_mosi)
        else $error("host data moved in high phase");
    a_bits: assert property (p_bits)
        else $error("frame ended without sixteen rises");
    a_max: assert property (p_max)
        else $error("frame longer than sixteen rises");
    a_zero: assert property (p_zero)
        else $error("unused status bit shifted as one");
endmodule

// ### tb/test_auto_frequency_control.sv
// Self-checking bench for the offset block and its host controller
`timescale 1ns/1ps
module test_auto_frequency_control;
    localparam int SETTLE = 4 * afc_pkg::MEAS_CYC;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic dv = 1'b0;
    logic [3:0] raw_offset = 4'h0;
    logic [11:0] base_word = 12'h100;
    logic [2:0] addr = 3'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic ce = 1'b1;
    logic [15:0] rdata;
    logic irq;
    logic [11:0] synth_word;
    logic [3:0] offset_value;
    logic [15:0] s;
    logic seen_base = 1'b0;
    logic watch = 1'b0;
    int bad_count = 0;
    int n_compared = 0;
    afc_spi_if i_afc_spi_if ();
    afc_dev i_afc_dev (.clk(clk), .rst_n(rst_n), .ce(ce),
        .spi(i_afc_spi_if), .dv(dv), .raw_offset(raw_offset),
        .base_word(base_word), .synth_word(synth_word),
        .offset_value(offset_value));
    afc_host i_afc_host (.clk(clk), .rst_n(rst_n), .ce(ce),
        .spi(i_afc_spi_if), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .irq(irq));
    afc_chk i_afc_chk (.clk(clk), .rst_n(rst_n),
        .sck(i_afc_spi_if.sck), .cs_n(i_afc_spi_if.cs_n),
        .mosi(i_afc_spi_if.mosi), .miso(i_afc_spi_if.miso));
    // Clock
    always #50 clk = ~clk;
    // Note whether the bare frequency word shows during a status read
    always @(posedge clk) begin
        if (watch && synth_word === base_word) begin
            seen_base <= 1'b1;
        end
    end
    task automatic test_done();
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tmo(input int i);
        if (i >= 200) begin
            bad_count++;
            $display("Error wait expected done seen timeout");
            test_done();
        end
    endtask
    task automatic reg_wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [2:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic wait_cs(input logic v);
        int i;
        for (i = 0; i < 200 && i_afc_spi_if.cs_n !== v; i++) begin
            @(posedge clk);
        end
        tmo(i);
    endtask
    // Write the control byte and let its frame land
    task automatic set_ctl(input logic [7:0] c);
        reg_wr(afc_pkg::HR_CTRL, {8'h00, c});
        wait_cs(1'b0);
        wait_cs(1'b1);
        repeat (3) @(posedge clk);
    endtask
    task automatic get_sts(output logic [15:0] v);
        logic [15:0] b;
        int i;
        reg_wr(afc_pkg::HR_CMD, 16'h0001);
        b = 16'h0001;
        for (i = 0; i < 200 && b[0] !== 1'b0; i++) begin
            reg_rd(afc_pkg::HR_CMD, b);
        end
        tmo(i);
        reg_rd(afc_pkg::HR_STATUS, v);
    endtask
    task automatic drive(input logic v, input logic [3:0] r);
        @(posedge clk);
        dv <= v;
        raw_offset <= r;
    endtask
    task automatic settle();
        repeat (SETTLE) @(posedge clk);
        #1;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk("offset", 16'h0000, 16'(offset_value));
        chk("synth", 16'h0100, 16'(synth_word));
        get_sts(s);
        chk("status", 16'h0000, s);
        reg_rd(3'h5, s);
        chk("unmapped", 16'h0000, s);
        $display("Test reset done");
        set_ctl(8'h40);
        drive(1'b1, 4'h2);
        settle();
        chk("once", 16'h0002, 16'(offset_value));
        drive(1'b1, 4'h4);
        settle();
        chk("once", 16'h0002, 16'(offset_value));
        $display("Test once done");
        set_ctl(8'h00);
        drive(1'b1, 4'h5);
        settle();
        chk("idle", 16'h0002, 16'(offset_value));
        get_sts(s);
        chk("status", 16'h0022, s);
        get_sts(s);
        chk("status", 16'h0002, s);
        set_ctl(8'h08);
        settle();
        chk("strobe", 16'h0005, 16'(offset_value));
        get_sts(s);
        chk("status", 16'h0025, s);
        $display("Test manual done");
        drive(1'b1, 4'hE);
        set_ctl(8'h09);
        settle();
        chk("offset", 16'h000E, 16'(offset_value));
        chk("synth", 16'h00FE, 16'(synth_word));
        watch = 1'b1;
        get_sts(s);
        watch = 1'b0;
        chk("status", 16'h002E, s);
        chk("apply off", 16'h0001, 16'(seen_base));
        chk("restore", 16'h00FE, 16'(synth_word));
        reg_rd(afc_pkg::HR_IRQ_STS, s);
        chk("irq sts", 16'h0003, s);
        chk("irq", 16'h0000, 16'(irq));
        reg_wr(afc_pkg::HR_IRQ_MASK, 16'h0003);
        repeat (2) @(posedge clk);
        #1 chk("irq", 16'h0001, 16'(irq));
        reg_wr(afc_pkg::HR_IRQ_STS, 16'h0003);
        repeat (2) @(posedge clk);
        #1 chk("irq", 16'h0000, 16'(irq));
        $display("Test apply done");
        set_ctl(8'hC0);
        reg_rd(afc_pkg::HR_CTRL, s);
        chk("ctrl", 16'h00C0, s);
        drive(1'b1, 4'h3);
        settle();
        chk("keep", 16'h0003, 16'(offset_value));
        drive(1'b0, 4'h3);
        settle();
        chk("keep", 16'h0003, 16'(offset_value));
        drive(1'b1, 4'h6);
        // Valid dips once every ten clocks, so no cycle is whole
        for (int i = 0; i < 8; i++) begin
            repeat (9) @(posedge clk);
            dv <= 1'b0;
            @(posedge clk);
            dv <= 1'b1;
        end
        #1 chk("gaps", 16'h0003, 16'(offset_value));
        settle();
        chk("keep", 16'h0006, 16'(offset_value));
        $display("Test keep done");
        set_ctl(8'h80);
        drive(1'b1, 4'h9);
        settle();
        chk("drop", 16'h0009, 16'(offset_value));
        // Clock enable low must hold the offset although valid fell
        @(posedge clk);
        ce <= 1'b0;
        drive(1'b0, 4'h9);
        repeat (3) @(posedge clk);
        #1 chk("freeze", 16'h0009, 16'(offset_value));
        @(posedge clk);
        ce <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk("drop", 16'h0000, 16'(offset_value));
        $display("Test drop done");
        test_done();
    end
endmodule
